// ==== rtl/odma_decoder.v ====
/*
 byte-serial decoder for data-transfer and basic arithmetic instructions.
 assumes the fetch queue offers one byte per BYTE_VALID_I and holds it
 until BYTE_READY_O; the datapath takes a result on DEC_VALID_O and DEC_READY_I.
*/
`timescale 1ns/1ps
`include "odma_defs.vh"
module odma_decoder (
    input  wire        REF_CLK_I,
    input  wire        RSTN_I,
    input  wire [7:0]  BYTE_I,
    input  wire        BYTE_VALID_I,
    output wire        BYTE_READY_O,
    input  wire        DEC_READY_I,
    output wire        DEC_VALID_O,
    output reg  [5:0]  DEC_OP_O,
    output reg  [7:0]  DEC_OPCODE_O,
    output reg  [7:0]  DEC_MODRM_O,
    output reg         DEC_HAS_MODRM_O,
    output reg         DEC_WORD_O,
    output reg         DEC_REG_DEST_O,
    output reg  [2:0]  DEC_SRC_O,
    output reg         DEC_MEM_ACCESS_O,
    output reg         DEC_FLAGS_ONLY_O,
    output reg  [15:0] DEC_DISP_O,
    output reg  [15:0] DEC_IMM_O,
    output reg  [15:0] DEC_ADDR_O,
    output reg         DEC_INVALID_O
);
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [1:0]  disp_need;
    reg  [1:0]  disp_cnt;
    reg  [1:0]  data_need;
    reg  [1:0]  data_cnt;
    reg  [1:0]  addr_need;
    reg         imm_mode;

    wire [5:0]  f_op;
    wire        f_modrm;
    wire [1:0]  f_imm;
    wire [1:0]  f_addr;
    wire        f_word;
    wire        f_dest;
    wire [2:0]  f_src;
    wire        f_known;
    wire [5:0]  m_op;
    wire        m_ok;

    odma_first_byte u_first (
        .opc_i         (state == `ODMA_ST_OPC ? BYTE_I : DEC_OPCODE_O),
        .op_o          (f_op),
        .needs_modrm_o (f_modrm),
        .imm_len_o     (f_imm),
        .addr_len_o    (f_addr),
        .word_o        (f_word),
        .reg_dest_o    (f_dest),
        .src_o         (f_src),
        .known_o       (f_known)
    );

    odma_modrm_check u_modrm (
        .opc_i      (DEC_OPCODE_O),
        .modrm_i    (BYTE_I),
        .op_first_i (DEC_OP_O),
        .op_o       (m_op),
        .ok_o       (m_ok)
    );

    wire        in_fetch = (state != `ODMA_ST_DONE);
    wire        take     = BYTE_VALID_I & in_fetch;
    wire [1:0]  md       = BYTE_I[`ODMA_MOD_HI:`ODMA_MOD_LO];
    wire [2:0]  rm       = BYTE_I[`ODMA_RM_HI:`ODMA_RM_LO];
    // displacement length from mode and r/m fields
    wire [1:0]  m_disp   = (md == 2'h1) ? 2'h1 :
                           (md == 2'h2) ? 2'h2 :
                           (md == 2'h0 && rm == 3'h6) ? 2'h2 : 2'h0;
    wire [1:0]  tail     = (f_addr != 2'h0) ? f_addr : f_imm;

    assign BYTE_READY_O = in_fetch;
    assign DEC_VALID_O  = (state == `ODMA_ST_DONE);

    always @* begin
        next_state = state;
        case (state)
            `ODMA_ST_OPC: begin
                if (take) begin
                    if (!f_known)
                        next_state = `ODMA_ST_DONE;
                    else if (f_modrm)
                        next_state = `ODMA_ST_MODRM;
                    else if (tail != 2'h0)
                        next_state = `ODMA_ST_DATA;
                    else
                        next_state = `ODMA_ST_DONE;
                end
            end
            `ODMA_ST_MODRM: begin
                if (take) begin
                    if (!m_ok)
                        next_state = `ODMA_ST_DONE;
                    else if (m_disp != 2'h0)
                        next_state = `ODMA_ST_DISP;
                    else if (data_need != 2'h0)
                        next_state = `ODMA_ST_DATA;
                    else
                        next_state = `ODMA_ST_DONE;
                end
            end
            `ODMA_ST_DISP: begin
                if (take && disp_cnt + 2'h1 == disp_need)
                    next_state = (data_need != 2'h0) ? `ODMA_ST_DATA : `ODMA_ST_DONE;
            end
            `ODMA_ST_DATA: begin
                if (take && data_cnt + 2'h1 == data_need)
                    next_state = `ODMA_ST_DONE;
            end
            `ODMA_ST_DONE: begin
                if (DEC_READY_I)
                    next_state = `ODMA_ST_OPC;
            end
            default: next_state = `ODMA_ST_OPC;
        endcase
    end

    always @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state            <= `ODMA_ST_OPC;
            disp_need        <= 2'h0;
            disp_cnt         <= 2'h0;
            data_need        <= 2'h0;
            data_cnt         <= 2'h0;
            addr_need        <= 2'h0;
            imm_mode         <= 1'b0;
            DEC_OP_O         <= `ODMA_OP_NONE;
            DEC_OPCODE_O     <= 8'h00;
            DEC_MODRM_O      <= 8'h00;
            DEC_HAS_MODRM_O  <= 1'b0;
            DEC_WORD_O       <= 1'b0;
            DEC_REG_DEST_O   <= 1'b0;
            DEC_SRC_O        <= `ODMA_SRC_NONE;
            DEC_MEM_ACCESS_O <= 1'b0;
            DEC_FLAGS_ONLY_O <= 1'b0;
            DEC_DISP_O       <= 16'h0000;
            DEC_IMM_O        <= 16'h0000;
            DEC_ADDR_O       <= 16'h0000;
            DEC_INVALID_O    <= 1'b0;
        end else begin
            state <= next_state;
            case (state)
                `ODMA_ST_OPC: begin
                    if (take) begin
                        DEC_OPCODE_O     <= BYTE_I;
                        DEC_OP_O         <= f_op;
                        DEC_HAS_MODRM_O  <= f_modrm;
                        DEC_MODRM_O      <= 8'h00;
                        DEC_WORD_O       <= f_word;
                        DEC_REG_DEST_O   <= f_dest;
                        DEC_SRC_O        <= f_src;
                        // address bytes count as memory access
                        DEC_MEM_ACCESS_O <= (f_addr != 2'h0) | (f_op == `ODMA_OP_XLATE);
                        DEC_FLAGS_ONLY_O <= (f_op == `ODMA_OP_CMP);
                        DEC_DISP_O       <= 16'h0000;
                        DEC_IMM_O        <= 16'h0000;
                        DEC_ADDR_O       <= 16'h0000;
                        DEC_INVALID_O    <= ~f_known;
                        data_need        <= f_modrm ? f_imm : tail;
                        addr_need        <= f_addr;
                        imm_mode         <= (f_addr == 2'h0);
                        disp_cnt         <= 2'h0;
                        data_cnt         <= 2'h0;
                    end
                end
                `ODMA_ST_MODRM: begin
                    if (take) begin
                        DEC_MODRM_O      <= BYTE_I;
                        DEC_OP_O         <= m_op;
                        disp_need        <= m_disp;
                        // address load never touches the operand
                        DEC_MEM_ACCESS_O <= (md != `ODMA_MOD_REGISTER) && (DEC_OP_O != `ODMA_OP_EA_LOAD);
                        DEC_FLAGS_ONLY_O <= (m_op == `ODMA_OP_CMP);
                        // bad operand field or mode flagged
                        DEC_INVALID_O    <= ~m_ok;
                    end
                end
                `ODMA_ST_DISP: begin
                    if (take) begin
                        if (disp_cnt == 2'h0)
                            DEC_DISP_O <= {{8{BYTE_I[7]}}, BYTE_I};
                        else
                            DEC_DISP_O <= {BYTE_I, DEC_DISP_O[7:0]};
                        disp_cnt <= disp_cnt + 2'h1;
                    end
                end
                `ODMA_ST_DATA: begin
                    if (take) begin
                        if (!imm_mode) begin
                            if (data_cnt == 2'h0)
                                DEC_ADDR_O <= {8'h00, BYTE_I};
                            else
                                DEC_ADDR_O <= {BYTE_I, DEC_ADDR_O[7:0]};
                        end else if (data_cnt == 2'h0) begin
                            DEC_IMM_O <= (DEC_WORD_O && data_need == 2'h1) ?
                                         {{8{BYTE_I[7]}}, BYTE_I} : {8'h00, BYTE_I};
                        end else begin
                            DEC_IMM_O <= {BYTE_I, DEC_IMM_O[7:0]};
                        end
                        data_cnt <= data_cnt + 2'h1;
                    end
                end
                default: begin
                    disp_cnt <= disp_cnt;
                end
            endcase
        end
    end
endmodule

// ==== rtl/odma_defs.vh ====
/*
 decoder constants: operation codes, operand classes, byte-sequencer states.
 included by the decoder modules; definitions only.
*/
`ifndef ODMA_DEFS_VH
`define ODMA_DEFS_VH

// operation classes
`define ODMA_OP_NONE        6'h00
`define ODMA_OP_MOVE        6'h01
`define ODMA_OP_MOVE_SEG    6'h02
`define ODMA_OP_MOVE_ACC    6'h03
`define ODMA_OP_PUSH        6'h04
`define ODMA_OP_POP         6'h05
`define ODMA_OP_SWAP        6'h06
`define ODMA_OP_EA_LOAD     6'h07
`define ODMA_OP_FAR_DS      6'h08
`define ODMA_OP_FAR_ES      6'h09
`define ODMA_OP_XLATE       6'h0A
`define ODMA_OP_FLAGS_TO_AH 6'h0B
`define ODMA_OP_AH_TO_FLAGS 6'h0C
`define ODMA_OP_FLAGS_PUSH  6'h0D
`define ODMA_OP_FLAGS_POP   6'h0E
`define ODMA_OP_ADD         6'h0F
`define ODMA_OP_ADC         6'h10
`define ODMA_OP_SUB         6'h11
`define ODMA_OP_SBB         6'h12
`define ODMA_OP_CMP         6'h13
`define ODMA_OP_INC         6'h14
`define ODMA_OP_DEC         6'h15

// operand sources
`define ODMA_SRC_NONE       3'h0
`define ODMA_SRC_MODRM      3'h1
`define ODMA_SRC_REG        3'h2
`define ODMA_SRC_SEG        3'h3
`define ODMA_SRC_IMM        3'h4
`define ODMA_SRC_ADDR       3'h5
`define ODMA_SRC_ACC        3'h6

// field positions in the operand byte
`define ODMA_MOD_HI         7
`define ODMA_MOD_LO         6
`define ODMA_REG_HI         5
`define ODMA_REG_LO         3
`define ODMA_RM_HI          2
`define ODMA_RM_LO          0
`define ODMA_MOD_REGISTER   2'h3

// sequencer states
`define ODMA_ST_OPC         3'h0
`define ODMA_ST_MODRM       3'h1
`define ODMA_ST_DISP        3'h2
`define ODMA_ST_DATA        3'h3
`define ODMA_ST_DONE        3'h4

`endif

// ==== rtl/odma_first_byte.v ====
/*
 combinational classifier of the opcode byte.
 assumes the operand byte is valid whenever needs_modrm is high.
*/
`timescale 1ns/1ps
`include "odma_defs.vh"
module odma_first_byte (
    input  wire [7:0] opc_i,
    output reg  [5:0] op_o,
    output reg        needs_modrm_o,
    output reg  [1:0] imm_len_o,
    output reg  [1:0] addr_len_o,
    output reg        word_o,
    output reg        reg_dest_o,
    output reg  [2:0] src_o,
    output reg        known_o
);
    wire w = opc_i[0];
    wire d = opc_i[1];
    wire [1:0] wimm = w ? 2'h2 : 2'h1;

    always @* begin
        op_o          = `ODMA_OP_NONE;
        needs_modrm_o = 1'b0;
        imm_len_o     = 2'h0;
        addr_len_o    = 2'h0;
        word_o        = w;
        reg_dest_o    = d;
        src_o         = `ODMA_SRC_NONE;
        known_o       = 1'b1;
        casez (opc_i)
            8'b1000_100?: begin op_o = `ODMA_OP_MOVE; needs_modrm_o = 1'b1; reg_dest_o = 1'b0; src_o = `ODMA_SRC_REG; end
            8'b1000_101?: begin op_o = `ODMA_OP_MOVE; needs_modrm_o = 1'b1; reg_dest_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'b1100_011?: begin op_o = `ODMA_OP_MOVE; needs_modrm_o = 1'b1; imm_len_o = wimm; src_o = `ODMA_SRC_IMM; end
            // accumulator and memory, low then high address
            8'b1010_000?: begin op_o = `ODMA_OP_MOVE_ACC; addr_len_o = 2'h2; reg_dest_o = 1'b1; src_o = `ODMA_SRC_ADDR; end
            8'b1010_001?: begin op_o = `ODMA_OP_MOVE_ACC; addr_len_o = 2'h2; reg_dest_o = 1'b0; src_o = `ODMA_SRC_ACC; end
            8'h8E: begin op_o = `ODMA_OP_MOVE_SEG; needs_modrm_o = 1'b1; word_o = 1'b1; reg_dest_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'h8C: begin op_o = `ODMA_OP_MOVE_SEG; needs_modrm_o = 1'b1; word_o = 1'b1; reg_dest_o = 1'b0; src_o = `ODMA_SRC_SEG; end
            8'hFF: begin op_o = `ODMA_OP_PUSH; needs_modrm_o = 1'b1; reg_dest_o = 1'b0; src_o = `ODMA_SRC_MODRM; end
            8'b0101_0???: begin op_o = `ODMA_OP_PUSH; word_o = 1'b1; src_o = `ODMA_SRC_REG; end
            8'b0110_10?0: begin op_o = `ODMA_OP_PUSH; word_o = 1'b1; src_o = `ODMA_SRC_IMM; imm_len_o = opc_i[1] ? 2'h1 : 2'h2; end
            8'b000?_?110: begin op_o = `ODMA_OP_PUSH; word_o = 1'b1; src_o = `ODMA_SRC_SEG; end
            // pop forms; segment code 01 refused
            8'h8F: begin op_o = `ODMA_OP_POP; needs_modrm_o = 1'b1; word_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'b0101_1???: begin op_o = `ODMA_OP_POP; word_o = 1'b1; src_o = `ODMA_SRC_REG; end
            8'b000?_?111: begin op_o = `ODMA_OP_POP; word_o = 1'b1; src_o = `ODMA_SRC_SEG; known_o = (opc_i[4:3] != 2'h1); end
            8'b1000_011?: begin op_o = `ODMA_OP_SWAP; needs_modrm_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'b1001_0???: begin op_o = `ODMA_OP_SWAP; word_o = 1'b1; src_o = `ODMA_SRC_REG; end
            8'h8D: begin op_o = `ODMA_OP_EA_LOAD; needs_modrm_o = 1'b1; word_o = 1'b1; reg_dest_o = 1'b1; end
            8'hC5: begin op_o = `ODMA_OP_FAR_DS; needs_modrm_o = 1'b1; word_o = 1'b1; reg_dest_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'hC4: begin op_o = `ODMA_OP_FAR_ES; needs_modrm_o = 1'b1; word_o = 1'b1; reg_dest_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'hD7: begin op_o = `ODMA_OP_XLATE; word_o = 1'b0; src_o = `ODMA_SRC_ACC; end
            8'h9F: begin op_o = `ODMA_OP_FLAGS_TO_AH; word_o = 1'b0; end
            8'h9E: begin op_o = `ODMA_OP_AH_TO_FLAGS; word_o = 1'b0; end
            8'h9C: begin op_o = `ODMA_OP_FLAGS_PUSH; word_o = 1'b1; end
            8'h9D: begin op_o = `ODMA_OP_FLAGS_POP; word_o = 1'b1; end
            // immediate group, operation from operand field
            8'b1000_00??: begin needs_modrm_o = 1'b1; src_o = `ODMA_SRC_IMM; imm_len_o = (opc_i[1:0] == 2'h1) ? 2'h2 : 2'h1; end
            8'b0000_010?: begin op_o = `ODMA_OP_ADD; imm_len_o = wimm; src_o = `ODMA_SRC_IMM; end
            8'b0001_010?: begin op_o = `ODMA_OP_ADC; imm_len_o = wimm; src_o = `ODMA_SRC_IMM; end
            8'b0010_110?: begin op_o = `ODMA_OP_SUB; imm_len_o = wimm; src_o = `ODMA_SRC_IMM; end
            8'b0001_110?: begin op_o = `ODMA_OP_SBB; imm_len_o = wimm; src_o = `ODMA_SRC_IMM; end
            8'b0011_110?: begin op_o = `ODMA_OP_CMP; imm_len_o = wimm; src_o = `ODMA_SRC_IMM; end
            8'b0001_00??: begin op_o = `ODMA_OP_ADC; needs_modrm_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'b0001_10??: begin op_o = `ODMA_OP_SBB; needs_modrm_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'hFE: begin needs_modrm_o = 1'b1; word_o = 1'b0; reg_dest_o = 1'b0; src_o = `ODMA_SRC_MODRM; end
            8'b0100_0???: begin op_o = `ODMA_OP_INC; word_o = 1'b1; src_o = `ODMA_SRC_REG; end
            8'b0100_1???: begin op_o = `ODMA_OP_DEC; word_o = 1'b1; src_o = `ODMA_SRC_REG; end
            8'b0011_101?: begin op_o = `ODMA_OP_CMP; needs_modrm_o = 1'b1; reg_dest_o = 1'b1; src_o = `ODMA_SRC_MODRM; end
            8'b0011_100?: begin op_o = `ODMA_OP_CMP; needs_modrm_o = 1'b1; reg_dest_o = 1'b0; src_o = `ODMA_SRC_REG; end
            default: known_o = 1'b0;
        endcase
    end
endmodule

// ==== rtl/odma_modrm_check.v ====
/*
 operand byte check: final operation and validity for opcodes whose
 meaning depends on the operand field or the mode field.
 assumes op_first comes from odma_first_byte for the same opcode.
*/
`timescale 1ns/1ps
`include "odma_defs.vh"
module odma_modrm_check (
    input  wire [7:0] opc_i,
    input  wire [7:0] modrm_i,
    input  wire [5:0] op_first_i,
    output reg  [5:0] op_o,
    output reg        ok_o
);
    wire [2:0] fld = modrm_i[`ODMA_REG_HI:`ODMA_REG_LO];
    wire [1:0] md  = modrm_i[`ODMA_MOD_HI:`ODMA_MOD_LO];

    always @* begin
        op_o = op_first_i;
        ok_o = 1'b1;
        casez (opc_i)
            8'b1100_011?: ok_o = (fld == 3'h0);
            // segment code has a leading 0
            8'h8E, 8'h8C: ok_o = ~fld[2];
            8'h8F: ok_o = (fld == 3'h0);
            8'hC4, 8'hC5: ok_o = (md != `ODMA_MOD_REGISTER);
            8'b1000_00??: begin
                case (fld)
                    3'h0: op_o = `ODMA_OP_ADD;
                    3'h2: op_o = `ODMA_OP_ADC;
                    3'h3: op_o = `ODMA_OP_SBB;
                    3'h5: op_o = `ODMA_OP_SUB;
                    3'h7: op_o = `ODMA_OP_CMP;
                    default: ok_o = 1'b0;
                endcase
            end
            8'hFE, 8'hFF: begin
                case (fld)
                    3'h0: op_o = `ODMA_OP_INC;
                    3'h1: op_o = `ODMA_OP_DEC;
                    3'h6: ok_o = opc_i[0];
                    default: ok_o = 1'b0;
                endcase
            end
            default: ok_o = 1'b1;
        endcase
    end
endmodule

// ==== testbench/odma_decoder_asserts.sv ====
/*
 port checker for odma_decoder: result handshake and decode relations.
 assumes a bind from the bench top; one clock, async active-low reset.
*/
`timescale 1ns/1ps
`include "odma_defs.vh"
module odma_decoder_asserts (
    input wire        REF_CLK_I,
    input wire        RSTN_I,
    input wire [7:0]  BYTE_I,
    input wire        BYTE_VALID_I,
    input wire        BYTE_READY_O,
    input wire        DEC_READY_I,
    input wire        DEC_VALID_O,
    input wire [5:0]  DEC_OP_O,
    input wire [7:0]  DEC_OPCODE_O,
    input wire [7:0]  DEC_MODRM_O,
    input wire        DEC_HAS_MODRM_O,
    input wire        DEC_WORD_O,
    input wire        DEC_REG_DEST_O,
    input wire        DEC_MEM_ACCESS_O,
    input wire        DEC_FLAGS_ONLY_O,
    input wire [15:0] DEC_IMM_O,
    input wire        DEC_INVALID_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);
    reg  start;
    wire take = BYTE_VALID_I && BYTE_READY_O;
    wire ok   = DEC_VALID_O && !DEC_INVALID_O;
    // next taken byte is an opcode
    always @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            start <= 1'b1;
        end else if (DEC_VALID_O && DEC_READY_I) begin
            start <= 1'b1;
        end else if (take) begin
            start <= 1'b0;
        end
    end
    sequence s_opc(logic [7:0] m, logic [7:0] v);
        start && take && ((BYTE_I & m) == v);
    endsequence
    sequence s_done(logic [5:0] op);
        ok && DEC_OP_O == op;
    endsequence
    chk_result_holds: assert property (DEC_VALID_O && !DEC_READY_I |=>
        DEC_VALID_O && $stable(DEC_OP_O) && $stable(DEC_IMM_O)) else $error("result moved before acceptance");
    chk_no_byte_done: assert property (DEC_VALID_O |-> !BYTE_READY_O)
        else $error("byte taken while result pending");
    chk_xlate_single: assert property (s_opc(8'hFF, 8'hD7) |=> s_done(`ODMA_OP_XLATE))
        else $error("table translate not decoded");
    chk_flags_load: assert property (s_opc(8'hFF, 8'h9F) |=> s_done(`ODMA_OP_FLAGS_TO_AH))
        else $error("flags load not decoded");
    chk_swap_acc: assert property (s_opc(8'hF8, 8'h90) |=> s_done(`ODMA_OP_SWAP))
        else $error("accumulator swap not decoded");
    chk_dec_reg: assert property (s_opc(8'hF8, 8'h48) |=> s_done(`ODMA_OP_DEC))
        else $error("register decrement not decoded");
    chk_push_reg: assert property (s_opc(8'hF8, 8'h50) |=> s_done(`ODMA_OP_PUSH))
        else $error("register push not decoded");
    chk_seg_pop_bad: assert property (s_opc(8'hFF, 8'h0F) |=> DEC_VALID_O && DEC_INVALID_O)
        else $error("segment pop code 01 accepted");
    chk_width_dir: assert property (ok && DEC_OPCODE_O[7:6] == 2'b00 && DEC_HAS_MODRM_O |->
        DEC_WORD_O == DEC_OPCODE_O[0] && DEC_REG_DEST_O == DEC_OPCODE_O[1]) else $error("width or direction wrong");
    chk_cmp_flags: assert property (ok |-> DEC_FLAGS_ONLY_O == (DEC_OP_O == `ODMA_OP_CMP))
        else $error("flags-only mark wrong");
    chk_ea_no_mem: assert property (ok && DEC_OP_O == `ODMA_OP_EA_LOAD |-> !DEC_MEM_ACCESS_O)
        else $error("address load touches memory");
    chk_far_mem: assert property (ok && (DEC_OP_O == `ODMA_OP_FAR_DS || DEC_OP_O == `ODMA_OP_FAR_ES) |->
        DEC_MODRM_O[7:6] != 2'b11) else $error("far load with register mode");
endmodule

// ==== testbench/odma_decoder_tb.sv ====
/*
 self-checking bench for odma_decoder: byte streams in, decode results compared.
 assumes the fetch model and the checker are compiled before this file.
*/
`timescale 1ns/1ps
`include "odma_defs.vh"
module odma_decoder_tb;
    logic        clk;
    logic        rst_n;
    wire  [7:0]  by;
    wire         bv, br, dr, dv, hm, wd, rd, mem, fo, inv;
    wire  [5:0]  op;
    wire  [7:0]  opc, mrm;
    wire  [2:0]  src;
    wire  [15:0] disp, imm, addr;
    int          bad_count;
    int          n_tests;
    odma_fetch_model odma_fetch_model_inst (.clk_i(clk), .byte_ready_i(br), .dec_valid_i(dv), .byte_o(by),
        .byte_valid_o(bv), .dec_ready_o(dr));
    odma_decoder odma_decoder_inst (.REF_CLK_I(clk), .RSTN_I(rst_n), .BYTE_I(by), .BYTE_VALID_I(bv),
        .BYTE_READY_O(br), .DEC_READY_I(dr), .DEC_VALID_O(dv), .DEC_OP_O(op), .DEC_OPCODE_O(opc),
        .DEC_MODRM_O(mrm), .DEC_HAS_MODRM_O(hm), .DEC_WORD_O(wd), .DEC_REG_DEST_O(rd), .DEC_SRC_O(src),
        .DEC_MEM_ACCESS_O(mem), .DEC_FLAGS_ONLY_O(fo), .DEC_DISP_O(disp), .DEC_IMM_O(imm),
        .DEC_ADDR_O(addr), .DEC_INVALID_O(inv));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // sel: 1 {word,dest} 2 imm 3 addr 4 disp 5 mem 6 flags-only 7 src
    task automatic dec(input logic [7:0] b[$], input logic [5:0] xo, input logic xi, input int sel,
                       input logic [15:0] fx);
        int          n;
        logic [15:0] v;
        foreach (b[i]) odma_fetch_model_inst.put(b[i]);
        for (n = 0; n < 40 && dv !== 1'b1; n++) @(negedge clk);
        chk("valid", {15'h0, dv}, 16'h0001);
        chk("invalid", {15'h0, inv}, {15'h0, xi});
        if (!xi) chk("op", {10'h0, op}, {10'h0, xo});
        case (sel)
            1: v = {14'h0, wd, rd};
            2: v = imm;
            3: v = addr;
            4: v = disp;
            5: v = {15'h0, mem};
            6: v = {15'h0, fo};
            7: v = {13'h0, src};
            default: v = 16'h0;
        endcase
        if (sel != 0) chk($sformatf("field%0d", sel), v, fx);
        for (n = 0; n < 40 && dv === 1'b1; n++) @(negedge clk);
    endtask
    task automatic t_move();
        dec('{8'h89, 8'hD8}, `ODMA_OP_MOVE, 1'b0, 1, 16'h0002);
        dec('{8'h8B, 8'h07}, `ODMA_OP_MOVE, 1'b0, 1, 16'h0003);
        dec('{8'h8A, 8'h46, 8'h05}, `ODMA_OP_MOVE, 1'b0, 4, 16'h0005);
        dec('{8'hC7, 8'h06, 8'h34, 8'h12, 8'h78, 8'h56}, `ODMA_OP_MOVE, 1'b0, 2, 16'h5678);
        dec('{8'hC6, 8'hC0, 8'h9A}, `ODMA_OP_MOVE, 1'b0, 2, 16'h009A);
        dec('{8'hC6, 8'hC8}, `ODMA_OP_NONE, 1'b1, 0, 16'h0);
        dec('{8'hA1, 8'hCD, 8'hAB}, `ODMA_OP_MOVE_ACC, 1'b0, 3, 16'hABCD);
        dec('{8'hA2, 8'h10, 8'h20}, `ODMA_OP_MOVE_ACC, 1'b0, 3, 16'h2010);
        dec('{8'h8E, 8'hD8}, `ODMA_OP_MOVE_SEG, 1'b0, 0, 16'h0);
        dec('{8'h8C, 8'hF0}, `ODMA_OP_NONE, 1'b1, 0, 16'h0);
        $display("test move done");
    endtask
    task automatic t_stack();
        dec('{8'hFF, 8'h36, 8'h00, 8'h10}, `ODMA_OP_PUSH, 1'b0, 4, 16'h1000);
        dec('{8'h53}, `ODMA_OP_PUSH, 1'b0, 0, 16'h0);
        dec('{8'h0E}, `ODMA_OP_PUSH, 1'b0, 0, 16'h0);
        dec('{8'h6A, 8'h80}, `ODMA_OP_PUSH, 1'b0, 2, 16'hFF80);
        dec('{8'h68, 8'h34, 8'h12}, `ODMA_OP_PUSH, 1'b0, 2, 16'h1234);
        dec('{8'h8F, 8'hC0}, `ODMA_OP_POP, 1'b0, 0, 16'h0);
        dec('{8'h5F}, `ODMA_OP_POP, 1'b0, 0, 16'h0);
        dec('{8'h1F}, `ODMA_OP_POP, 1'b0, 0, 16'h0);
        dec('{8'h0F}, `ODMA_OP_NONE, 1'b1, 0, 16'h0);
        $display("test stack done");
    endtask
    task automatic t_xfer();
        logic [5:0] fl[4] = '{`ODMA_OP_FLAGS_PUSH, `ODMA_OP_FLAGS_POP, `ODMA_OP_AH_TO_FLAGS, `ODMA_OP_FLAGS_TO_AH};
        odma_fetch_model_inst.stall = 3;
        dec('{8'h87, 8'hCA}, `ODMA_OP_SWAP, 1'b0, 1, 16'h0003);
        odma_fetch_model_inst.stall = 0;
        dec('{8'h91}, `ODMA_OP_SWAP, 1'b0, 7, {13'h0, `ODMA_SRC_REG});
        dec('{8'h8D, 8'h07}, `ODMA_OP_EA_LOAD, 1'b0, 5, 16'h0000);
        dec('{8'hC5, 8'hC0}, `ODMA_OP_NONE, 1'b1, 0, 16'h0);
        dec('{8'hC4, 8'h07}, `ODMA_OP_FAR_ES, 1'b0, 0, 16'h0);
        dec('{8'hC5, 8'h06, 8'h00, 8'h20}, `ODMA_OP_FAR_DS, 1'b0, 4, 16'h2000);
        dec('{8'hD7}, `ODMA_OP_XLATE, 1'b0, 0, 16'h0);
        for (int i = 0; i < 4; i++) dec('{8'h9C + 8'(i)}, fl[i], 1'b0, 0, 16'h0);
        $display("test transfer done");
    endtask
    task automatic t_arith();
        logic [2:0] gf[5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
        logic [5:0] go[5] = '{`ODMA_OP_ADD, `ODMA_OP_ADC, `ODMA_OP_SBB, `ODMA_OP_SUB, `ODMA_OP_CMP};
        logic [7:0] ac[5] = '{8'h05, 8'h15, 8'h1D, 8'h2D, 8'h3D};
        for (int i = 0; i < 5; i++) dec('{8'h81, {2'b11, gf[i], 3'h0}, 8'h34, 8'h12}, go[i], 1'b0, 2, 16'h1234);
        for (int i = 0; i < 5; i++) dec('{ac[i], 8'h34, 8'h12}, go[i], 1'b0, 2, 16'h1234);
        dec('{8'h83, 8'hF8, 8'h80}, `ODMA_OP_CMP, 1'b0, 2, 16'hFF80);
        dec('{8'h80, 8'hC8}, `ODMA_OP_NONE, 1'b1, 0, 16'h0);
        dec('{8'h3C, 8'h7F}, `ODMA_OP_CMP, 1'b0, 2, 16'h007F);
        dec('{8'h12, 8'hC1}, `ODMA_OP_ADC, 1'b0, 1, 16'h0001);
        dec('{8'h19, 8'hD8}, `ODMA_OP_SBB, 1'b0, 1, 16'h0002);
        dec('{8'hFE, 8'hC0}, `ODMA_OP_INC, 1'b0, 1, 16'h0000);
        dec('{8'hFF, 8'hC9}, `ODMA_OP_DEC, 1'b0, 0, 16'h0);
        dec('{8'hFE, 8'hD0}, `ODMA_OP_NONE, 1'b1, 0, 16'h0);
        dec('{8'h40}, `ODMA_OP_INC, 1'b0, 0, 16'h0);
        dec('{8'h4F}, `ODMA_OP_DEC, 1'b0, 0, 16'h0);
        dec('{8'h3B, 8'hC1}, `ODMA_OP_CMP, 1'b0, 6, 16'h0001);
        dec('{8'h38, 8'hC1}, `ODMA_OP_CMP, 1'b0, 1, 16'h0000);
        dec('{8'h60}, `ODMA_OP_NONE, 1'b1, 0, 16'h0);
        $display("test arith done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
    initial begin
        bad_count = 0;
        n_tests = 0;
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_move();
        t_stack();
        t_xfer();
        t_arith();
        final_report();
    end
endmodule
bind odma_decoder odma_decoder_asserts odma_decoder_asserts_inst (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
    .BYTE_I(BYTE_I), .BYTE_VALID_I(BYTE_VALID_I), .BYTE_READY_O(BYTE_READY_O), .DEC_READY_I(DEC_READY_I),
    .DEC_VALID_O(DEC_VALID_O), .DEC_OP_O(DEC_OP_O), .DEC_OPCODE_O(DEC_OPCODE_O), .DEC_MODRM_O(DEC_MODRM_O),
    .DEC_HAS_MODRM_O(DEC_HAS_MODRM_O), .DEC_WORD_O(DEC_WORD_O), .DEC_REG_DEST_O(DEC_REG_DEST_O),
    .DEC_MEM_ACCESS_O(DEC_MEM_ACCESS_O), .DEC_FLAGS_ONLY_O(DEC_FLAGS_ONLY_O), .DEC_IMM_O(DEC_IMM_O),
    .DEC_INVALID_O(DEC_INVALID_O));

// ==== testbench/odma_fetch_model.sv ====
/*
 fetch queue and datapath stand-in for odma_decoder.
 assumes the bench queues bytes through put; outputs change on falling edges.
*/
`timescale 1ns/1ps
module odma_fetch_model (
    input  wire        clk_i,
    input  wire        byte_ready_i,
    input  wire        dec_valid_i,
    output logic [7:0] byte_o,
    output logic       byte_valid_o,
    output logic       dec_ready_o
);
    logic [7:0] q[$];
    int         stall;
    int         hold;
    logic       took;
    initial begin
        byte_o = 8'h00;
        byte_valid_o = 1'b0;
        dec_ready_o = 1'b0;
        stall = 0;
        hold = 0;
        took = 1'b0;
    end
    task automatic put(input logic [7:0] b);
        q.push_back(b);
    endtask
    always @(posedge clk_i) begin
        took <= byte_valid_o && byte_ready_i;
    end
    always @(negedge clk_i) begin
        if (took && q.size() > 0) begin
            void'(q.pop_front());
        end
        // idle bus inverts the last byte on each falling edge
        byte_o <= (q.size() > 0) ? q[0] : ~byte_o;
        byte_valid_o <= q.size() > 0;
        if (!dec_valid_i) begin
            hold = stall;
        end else if (hold > 0) begin
            hold--;
        end
        dec_ready_o <= dec_valid_i && hold == 0;
    end
endmodule
